// ==== src/spt_map.vh ====
// Register offsets, field positions, reset values and timing counts of the serial port.
`ifndef SPT_MAP_VH
`define SPT_MAP_VH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define SPT_OFS_CTRL      8'h00
`define SPT_OFS_PEND      8'h04
`define SPT_OFS_DATA      8'h08
`define SPT_OFS_DIV_HIGH  8'h0C
`define SPT_OFS_DIV_LOW   8'h10

// ****************************************************************
// Control register fields
// ****************************************************************
`define SPT_CTRL_MODE_HI  7
`define SPT_CTRL_MODE_LO  6
`define SPT_CTRL_MPE      5
`define SPT_CTRL_RE       4
`define SPT_CTRL_TX9      3
`define SPT_CTRL_RX9      2
`define SPT_CTRL_RIE      1
`define SPT_CTRL_TIE      0
`define SPT_MODE_SYNC     2'h0
`define SPT_MODE_ASYNC8   2'h1

// ****************************************************************
// Pending register fields
// ****************************************************************
`define SPT_PEND_TX       0
`define SPT_PEND_RX       1
`define SPT_PEND_PERR     2
`define SPT_PEND_OVR      3
`define SPT_PEND_PEN      5

// ****************************************************************
// Reset values
// ****************************************************************
`define SPT_RST_CTRL      8'h00
`define SPT_RST_DIV       8'h00

// ****************************************************************
// Timing counts
// ****************************************************************
`define SPT_OVERSAMPLE    4'hF
`define SPT_MID_TICK      4'h7
`define SPT_BITS_SYNC     4'h8
`define SPT_BITS_ASYNC8   4'hA
`define SPT_BITS_ASYNC9   4'hB

`endif

// ==== src/spt_top.v ====
// Three-mode serial port with an APB register slave.
//
// The APB slave port and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
`include "spt_map.vh"

module spt_top #(
    parameter ADDR_W = 8
) (
    // APB clock and reset
    input  wire              pclk,
    input  wire              presetn,
    // APB slave
    input  wire              psel,
    input  wire              penable,
    input  wire              pwrite,
    input  wire [ADDR_W-1:0] paddr,
    input  wire [31:0]       pwdata,
    output wire [31:0]       prdata,
    output wire              pready,
    output wire              pslverr,
    // Serial pins
    input  wire              rxd_in,
    output wire              rxd_out,
    output wire              rxd_oe_n,
    output wire              txd_out,
    // Interrupt requests
    output wire              rx_irq,
    output wire              tx_irq
);

    localparam T_IDLE  = 2'b01;
    localparam T_RUN   = 2'b10;
    localparam R_IDLE  = 3'b001;
    localparam R_ASYNC = 3'b010;
    localparam R_SYNC  = 3'b100;

    // ****************************************************************
    // Declarations
    // ****************************************************************
    reg  [7:0]  ctrl_reg;
    reg         tx_pend_reg;
    reg         rx_pend_reg;
    reg         perr_reg;
    reg         ovr_reg;
    reg         pen_reg;
    reg  [7:0]  rxbuf_reg;
    reg  [7:0]  div_high_reg;
    reg  [7:0]  div_low_reg;
    reg  [31:0] prdata_reg;
    reg         pready_reg;
    reg         pslverr_reg;
    reg  [15:0] baud_cnt_reg;
    reg         tick_reg;
    reg  [1:0]  tx_state_reg;
    reg  [10:0] tx_shift_reg;
    reg  [3:0]  tx_bits_reg;
    reg  [3:0]  tx_sub_reg;
    reg         tx_set_reg;
    reg  [2:0]  rx_state_reg;
    reg  [3:0]  rx_sub_reg;
    reg  [3:0]  rx_idx_reg;
    reg  [7:0]  rx_data_reg;
    reg         rx_ninth_reg;
    reg         rx_stop_reg;
    reg         rx_done_reg;
    reg         txd_reg;
    reg         rxd_out_reg;
    reg         rxd_oe_n_reg;
    reg         rx_irq_reg;
    reg         tx_irq_reg;
    reg  [7:0]  rd_next;
    reg         hit_next;

    wire [1:0]  mode      = ctrl_reg[`SPT_CTRL_MODE_HI:`SPT_CTRL_MODE_LO];
    wire        mode_sync = (mode == `SPT_MODE_SYNC);
    wire        mode_a8   = (mode == `SPT_MODE_ASYNC8);
    wire        mode_a9   = mode[1];
    wire        rx_en     = ctrl_reg[`SPT_CTRL_RE];
    wire        mpe       = ctrl_reg[`SPT_CTRL_MPE];
    wire [15:0] divisor   = {div_high_reg, div_low_reg};
    wire        setup     = psel & ~penable;
    wire        wr_en     = psel & penable & pready_reg & pwrite & ~pslverr_reg;
    wire [7:0]  ofs       = paddr[7:0];
    wire        tx_start  = wr_en & (ofs == `SPT_OFS_DATA);
    wire        tx_ninth  = pen_reg ? (^pwdata[7:0] ^ ctrl_reg[`SPT_CTRL_TX9])
                                    : ctrl_reg[`SPT_CTRL_TX9];
    // Frames that fail the multiprocessor filter store data but raise no flag.
    wire        rx_filt   = mpe & ((mode_a8 & ~rx_stop_reg)
                                 | (mode_a9 & ~pen_reg & ~rx_ninth_reg));
    wire        rx_set    = rx_done_reg & ~rx_filt;
    wire        sync_tx   = (tx_state_reg == T_RUN) & mode_sync;

    // ****************************************************************
    // APB slave: answers in the first access cycle
    // ****************************************************************
    always @* begin
        hit_next = 1'b1;
        rd_next  = 8'h00;
        case (ofs)
            `SPT_OFS_CTRL:     rd_next = ctrl_reg;
            `SPT_OFS_PEND:     rd_next = {2'b00, pen_reg, 1'b0, ovr_reg, perr_reg,
                                          rx_pend_reg, tx_pend_reg};
            `SPT_OFS_DATA:     rd_next = rxbuf_reg;
            `SPT_OFS_DIV_HIGH: rd_next = div_high_reg;
            `SPT_OFS_DIV_LOW:  rd_next = div_low_reg;
            default:           hit_next = 1'b0;
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg  <= 32'h00000000;
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
        end else begin
            pready_reg  <= setup;
            pslverr_reg <= setup & ~hit_next;
            if (setup) begin
                prdata_reg <= {24'h000000, rd_next};
            end
        end
    end

    // ****************************************************************
    // Register file; hardware set wins over a software clear
    // ****************************************************************
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg     <= `SPT_RST_CTRL;
            tx_pend_reg  <= 1'b0;
            rx_pend_reg  <= 1'b0;
            perr_reg     <= 1'b0;
            ovr_reg      <= 1'b0;
            pen_reg      <= 1'b0;
            rxbuf_reg    <= 8'h00;
            div_high_reg <= `SPT_RST_DIV;
            div_low_reg  <= `SPT_RST_DIV;
        end else begin
            if (wr_en) begin
                case (ofs)
                    `SPT_OFS_CTRL: ctrl_reg <= pwdata[7:0];
                    `SPT_OFS_PEND: begin
                        tx_pend_reg <= pwdata[`SPT_PEND_TX];
                        rx_pend_reg <= pwdata[`SPT_PEND_RX];
                        perr_reg    <= pwdata[`SPT_PEND_PERR];
                        ovr_reg     <= pwdata[`SPT_PEND_OVR];
                        pen_reg     <= pwdata[`SPT_PEND_PEN];
                    end
                    `SPT_OFS_DIV_HIGH: div_high_reg <= pwdata[7:0];
                    `SPT_OFS_DIV_LOW:  div_low_reg  <= pwdata[7:0];
                    default: ;
                endcase
            end
            if (tx_set_reg) begin
                tx_pend_reg <= 1'b1;
            end
            if (rx_done_reg) begin
                rxbuf_reg <= rx_data_reg;
                if (mode_a8) begin
                    ctrl_reg[`SPT_CTRL_RX9] <= rx_stop_reg;
                end else if (mode_a9 & ~pen_reg) begin
                    ctrl_reg[`SPT_CTRL_RX9] <= rx_ninth_reg;
                end else if (mode_a9) begin
                    // Ninth bit must match data parity of the selected type.
                    perr_reg <= rx_ninth_reg ^ (^rx_data_reg)
                              ^ ctrl_reg[`SPT_CTRL_RX9];
                end
            end
            if (rx_set) begin
                rx_pend_reg <= 1'b1;
                if (rx_pend_reg) begin
                    ovr_reg <= 1'b1;
                end
            end
        end
    end

    // ****************************************************************
    // Baud tick: one pulse every divisor plus one clocks
    // ****************************************************************
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            baud_cnt_reg <= 16'h0000;
            tick_reg     <= 1'b0;
        end else begin
            if (baud_cnt_reg >= divisor) begin
                baud_cnt_reg <= 16'h0000;
                tick_reg     <= 1'b1;
            end else begin
                baud_cnt_reg <= baud_cnt_reg + 16'h0001;
                tick_reg     <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Transmitter
    // ****************************************************************
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_state_reg <= T_IDLE;
            tx_shift_reg <= 11'h7FF;
            tx_bits_reg  <= 4'h0;
            tx_sub_reg   <= 4'h0;
            tx_set_reg   <= 1'b0;
        end else begin
            tx_set_reg <= 1'b0;
            if (tx_start) begin
                tx_state_reg <= T_RUN;
                tx_sub_reg   <= 4'h0;
                if (mode_sync) begin
                    tx_shift_reg <= {3'h7, pwdata[7:0]};
                    tx_bits_reg  <= `SPT_BITS_SYNC;
                end else if (mode_a9) begin
                    tx_shift_reg <= {1'b1, tx_ninth, pwdata[7:0], 1'b0};
                    tx_bits_reg  <= `SPT_BITS_ASYNC9;
                end else begin
                    tx_shift_reg <= {2'h3, pwdata[7:0], 1'b0};
                    tx_bits_reg  <= `SPT_BITS_ASYNC8;
                end
            end else begin
                case (tx_state_reg)
                    T_IDLE: tx_sub_reg <= 4'h0;
                    T_RUN: begin
                        if (tick_reg) begin
                            tx_sub_reg <= tx_sub_reg + 4'h1;
                            if (tx_sub_reg == `SPT_OVERSAMPLE) begin
                                tx_shift_reg <= {1'b1, tx_shift_reg[10:1]};
                                tx_bits_reg  <= tx_bits_reg - 4'h1;
                                if (tx_bits_reg == 4'h2 && !mode_sync) begin
                                    tx_set_reg <= 1'b1;
                                end
                                if (tx_bits_reg == 4'h1) begin
                                    tx_state_reg <= T_IDLE;
                                    tx_set_reg   <= mode_sync;
                                end
                            end
                        end
                    end
                    default: tx_state_reg <= T_IDLE;
                endcase
            end
        end
    end

    // ****************************************************************
    // Receiver
    // ****************************************************************
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_state_reg <= R_IDLE;
            rx_sub_reg   <= 4'h0;
            rx_idx_reg   <= 4'h0;
            rx_data_reg  <= 8'h00;
            rx_ninth_reg <= 1'b0;
            rx_stop_reg  <= 1'b0;
            rx_done_reg  <= 1'b0;
        end else begin
            rx_done_reg <= 1'b0;
            case (rx_state_reg)
                R_IDLE: begin
                    rx_sub_reg <= 4'h0;
                    rx_idx_reg <= 4'h0;
                    if (rx_en) begin
                        if (mode_sync) begin
                            // A finished byte raises its flag one clock late; do not restart.
                            if (!rx_pend_reg && !rx_done_reg
                                && tx_state_reg == T_IDLE && !tx_start) begin
                                rx_state_reg <= R_SYNC;
                            end
                        end else if (!rxd_in) begin
                            rx_state_reg <= R_ASYNC;
                        end
                    end
                end
                R_ASYNC: begin
                    if (!rx_en || mode_sync) begin
                        rx_state_reg <= R_IDLE;
                    end else if (tick_reg) begin
                        rx_sub_reg <= rx_sub_reg + 4'h1;
                        if (rx_sub_reg == `SPT_MID_TICK) begin
                            if (rx_idx_reg == 4'h0) begin
                                // A start bit that is gone by mid-bit was a glitch.
                                if (rxd_in) begin
                                    rx_state_reg <= R_IDLE;
                                end
                            end else if (rx_idx_reg <= 4'h8) begin
                                rx_data_reg <= {rxd_in, rx_data_reg[7:1]};
                            end else if (rx_idx_reg == 4'h9 && mode_a9) begin
                                rx_ninth_reg <= rxd_in;
                            end else begin
                                rx_stop_reg  <= rxd_in;
                                rx_done_reg  <= 1'b1;
                                rx_state_reg <= R_IDLE;
                            end
                        end
                        if (rx_sub_reg == `SPT_OVERSAMPLE) begin
                            rx_idx_reg <= rx_idx_reg + 4'h1;
                        end
                    end
                end
                R_SYNC: begin
                    if (tick_reg) begin
                        rx_sub_reg <= rx_sub_reg + 4'h1;
                        if (rx_sub_reg == `SPT_MID_TICK) begin
                            rx_data_reg <= {rxd_in, rx_data_reg[7:1]};
                        end
                        if (rx_sub_reg == `SPT_OVERSAMPLE) begin
                            rx_idx_reg <= rx_idx_reg + 4'h1;
                            if (rx_idx_reg == `SPT_BITS_SYNC - 4'h1) begin
                                rx_done_reg  <= 1'b1;
                                rx_state_reg <= R_IDLE;
                            end
                        end
                    end
                end
                default: rx_state_reg <= R_IDLE;
            endcase
        end
    end

    // ****************************************************************
    // Pin and request outputs
    // ****************************************************************
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            txd_reg      <= 1'b1;
            rxd_out_reg  <= 1'b1;
            rxd_oe_n_reg <= 1'b1;
            rx_irq_reg   <= 1'b0;
            tx_irq_reg   <= 1'b0;
        end else begin
            // Shift clock is low for the first half of each bit, high otherwise.
            if (sync_tx) begin
                txd_reg <= tx_sub_reg[3];
            end else if (rx_state_reg == R_SYNC) begin
                txd_reg <= rx_sub_reg[3];
            end else if (tx_state_reg == T_RUN && !mode_sync) begin
                txd_reg <= tx_shift_reg[0];
            end else begin
                txd_reg <= 1'b1;
            end
            rxd_out_reg  <= tx_shift_reg[0];
            rxd_oe_n_reg <= ~sync_tx;
            rx_irq_reg   <= rx_pend_reg & ctrl_reg[`SPT_CTRL_RIE];
            tx_irq_reg   <= tx_pend_reg & ctrl_reg[`SPT_CTRL_TIE];
        end
    end

    assign prdata   = prdata_reg;
    assign pready   = pready_reg;
    assign pslverr  = pslverr_reg;
    assign txd_out  = txd_reg;
    assign rxd_out  = rxd_out_reg;
    assign rxd_oe_n = rxd_oe_n_reg;
    assign rx_irq   = rx_irq_reg;
    assign tx_irq   = tx_irq_reg;

endmodule

// ==== verif/spt_top_sva.sv ====
// Port-level checker for the three-mode serial port.
`timescale 1ns/10ps
module spt_top_sva #(
    parameter ADDR_W = 8
) (
    // APB side
    input wire              pclk,
    input wire              presetn,
    input wire              psel,
    input wire              penable,
    input wire              pwrite,
    input wire [ADDR_W-1:0] paddr,
    input wire [31:0]       pwdata,
    input wire [31:0]       prdata,
    input wire              pready,
    input wire              pslverr,
    // Serial pins and requests
    input wire              rxd_in,
    input wire              rxd_out,
    input wire              rxd_oe_n,
    input wire              txd_out,
    input wire              rx_irq,
    input wire              tx_irq
);
    reg  [7:0]  ctl_reg;
    reg  [15:0] div_reg;
    reg  [7:0]  low_reg;
    wire        wr  = psel & penable & pready & pwrite & ~pslverr;
    wire        asy = ctl_reg[7:6] != 2'h0;
    // Shadows of control and divisor, and the length of the current low run on the line.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl_reg <= 8'h00;
            div_reg <= 16'h0000;
            low_reg <= 8'h00;
        end else begin
            if (wr && paddr == 8'h00) ctl_reg <= pwdata[7:0];
            if (wr && paddr == 8'h0C) div_reg[15:8] <= pwdata[7:0];
            if (wr && paddr == 8'h10) div_reg[7:0] <= pwdata[7:0];
            low_reg <= txd_out ? 8'h00 : low_reg + 8'h01;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_ready; psel && !penable |=> pready && penable; endproperty
    property p_ready_only; pready |-> psel && penable && $past(psel && !penable); endproperty
    property p_unmapped; pready && paddr > 8'h10 |-> pslverr; endproperty
    property p_rdata_hi; pready |-> prdata[31:8] == 24'h000000; endproperty
    property p_rx_irq; rx_irq |-> ctl_reg[1] || $past(ctl_reg[1]); endproperty
    property p_oe_sync; !rxd_oe_n |-> !asy || $past(ctl_reg[7:6]) == 2'h0; endproperty
    property p_bit_len;
        $rose(txd_out) && asy && div_reg == 16'h0000 |-> low_reg[3:0] == 4'h0;
    endproperty
    property p_tx_start; wr && paddr == 8'h08 && asy && txd_out |-> ##[1:3] !txd_out; endproperty
    property p_sync_clk;
        $fell(txd_out) && !asy && div_reg == 16'h0000 |-> !txd_out [*8] ##1 txd_out;
    endproperty
    a_ready: assert property (p_ready) else $error("no ready after setup");
    a_ready_only: assert property (p_ready_only) else $error("ready outside access");
    a_unmapped: assert property (p_unmapped) else $error("no error on unmapped address");
    a_rdata_hi: assert property (p_rdata_hi) else $error("read data upper bits set");
    a_rx_irq: assert property (p_rx_irq) else $error("receive request while disabled");
    a_oe_sync: assert property (p_oe_sync) else $error("data pin driven in async mode");
    a_bit_len: assert property (p_bit_len) else $error("low run not whole bits");
    a_tx_start: assert property (p_tx_start) else $error("no start bit");
    a_sync_clk: assert property (p_sync_clk) else $error("shift clock low phase");
    c_tx: cover property (wr && paddr == 8'h08);
    c_rx_irq: cover property ($rose(rx_irq));
    c_err: cover property (pslverr);
endmodule
bind spt_top spt_top_sva #(.ADDR_W(ADDR_W)) u_sva (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rxd_in(rxd_in), .rxd_out(rxd_out), .rxd_oe_n(rxd_oe_n), .txd_out(txd_out),
    .rx_irq(rx_irq), .tx_irq(tx_irq));

// ==== verif/spt_peer.sv ====
// Far-side serial node: async frame sender and receiver, shift-mode slave.
`timescale 1ns/10ps
module spt_peer (
    // Clock and mode
    input  wire       pclk,
    input  wire       sync_mode,
    input  wire [7:0] bitc,
    // Line
    input  wire       line_in,
    input  wire       rxd_pin,
    output wire       line_out
);
    reg       aline_reg = 1'b1;
    reg [7:0] drv_reg   = 8'h00;
    reg [7:0] cap_reg   = 8'h00;
    assign line_out = sync_mode ? drv_reg[0] : aline_reg;
    // Shift mode: take the device bit and present the next one on each rising shift clock.
    always @(posedge line_in) begin
        if (sync_mode) begin
            cap_reg <= {rxd_pin, cap_reg[7:1]};
            drv_reg <= drv_reg >> 1;
        end
    end
    task automatic send(input [10:0] bits, input int n);
        for (int i = 0; i < n; i++) begin
            aline_reg <= bits[i];
            repeat (bitc) @(posedge pclk);
        end
        aline_reg <= 1'b1;
    endtask
    task automatic recv(output [10:0] bits, input int n);
        int k;
        k = 0;
        bits = 11'h000;
        while (line_in !== 1'b0 && k < 4000) begin
            @(posedge pclk);
            k++;
        end
        repeat (bitc / 2) @(posedge pclk);
        for (int i = 0; i < n; i++) begin
            bits[i] = line_in;
            repeat (bitc) @(posedge pclk);
        end
    endtask
endmodule

// ==== verif/tb.sv ====
// Self-checking bench for the three-mode serial port.
`timescale 1ns/10ps
`include "spt_map.vh"
module tb;
    reg         pclk      = 1'b0;
    reg         presetn   = 1'b0;
    reg         psel      = 1'b0;
    reg         penable   = 1'b0;
    reg         pwrite    = 1'b0;
    reg  [7:0]  paddr     = 8'h00;
    reg  [31:0] pwdata    = 32'h0;
    reg         sync_mode = 1'b0;
    reg  [7:0]  bitc      = 8'h10;
    wire [31:0] prdata;
    wire        pready, pslverr, rxd_out, rxd_oe_n, txd_out, rx_irq, tx_irq, peer_out;
    wire        rxd_wire  = rxd_oe_n ? peer_out : rxd_out;
    int         failures  = 0;
    int         tests_run = 0;
    reg  [31:0] rd;
    reg         er;
    reg  [10:0] fr;
    always #12.5 pclk = ~pclk;
    spt_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rxd_in(rxd_wire), .rxd_out(rxd_out), .rxd_oe_n(rxd_oe_n),
        .txd_out(txd_out), .rx_irq(rx_irq), .tx_irq(tx_irq));
    spt_peer peer (.pclk(pclk), .sync_mode(sync_mode), .bitc(bitc), .line_in(txd_out),
        .rxd_pin(rxd_wire), .line_out(peer_out));
    task automatic chk(input [31:0] got, input [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic apb(input w, input [7:0] a, input [7:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) begin
            failures++;
            $display("[FAIL] t=%0t pready got=%h exp=%h", $time, pready, 1'b1);
        end
    endtask
    task automatic t_regs;
        apb(0, `SPT_OFS_CTRL, 8'h00);
        chk(rd, 32'h0);
        apb(1, `SPT_OFS_DIV_HIGH, 8'h12);
        apb(1, `SPT_OFS_DIV_LOW, 8'h01);
        apb(0, `SPT_OFS_DIV_HIGH, 8'h00);
        chk(rd, 32'h12);
        apb(0, `SPT_OFS_DIV_LOW, 8'h00);
        chk(rd, 32'h01);
        apb(0, 8'h40, 8'h00);
        chk({rd[30:0], er}, 32'h1);
        apb(1, `SPT_OFS_DIV_HIGH, 8'h00);
        $display("test regs done");
    endtask
    task automatic t_async8;
        bitc = 8'h20;
        apb(1, `SPT_OFS_CTRL, 8'h50);
        apb(1, `SPT_OFS_DATA, 8'hA5);
        peer.recv(fr, 10);
        chk(fr, {1'b1, 8'hA5, 1'b0});
        chk(tx_irq, 32'h0);
        apb(0, `SPT_OFS_PEND, 8'h00);
        chk(rd, 32'h1);
        apb(1, `SPT_OFS_PEND, 8'h00);
        peer.send({1'b1, 8'h3C, 1'b0}, 10);
        apb(0, `SPT_OFS_PEND, 8'h00);
        chk(rd, 32'h2);
        apb(0, `SPT_OFS_DATA, 8'h00);
        chk(rd, 32'h3C);
        apb(0, `SPT_OFS_CTRL, 8'h00);
        chk(rd, 32'h54);
        apb(1, `SPT_OFS_PEND, 8'h00);
        apb(1, `SPT_OFS_DIV_LOW, 8'h00);
        bitc = 8'h10;
        apb(1, `SPT_OFS_CTRL, 8'h70);
        peer.send({2'b10, 8'h3C, 1'b0}, 11);
        apb(0, `SPT_OFS_PEND, 8'h00);
        chk(rd, 32'h0);
        $display("test async8 done");
    endtask
    task automatic t_async9;
        apb(1, `SPT_OFS_CTRL, 8'h99);
        apb(1, `SPT_OFS_DATA, 8'h5B);
        peer.recv(fr, 11);
        chk(fr, {2'b11, 8'h5B, 1'b0});
        chk(tx_irq, 32'h1);
        for (int p = 0; p < 2; p++) begin
            apb(1, `SPT_OFS_PEND, 8'h20);
            apb(1, `SPT_OFS_CTRL, p[0] ? 8'h98 : 8'h90);
            apb(1, `SPT_OFS_DATA, 8'h5B);
            peer.recv(fr, 11);
            chk(fr[9], (^8'h5B) ^ p[0]);
        end
        apb(1, `SPT_OFS_PEND, 8'h20);
        peer.send({2'b10, 8'h5B, 1'b0}, 11);
        apb(0, `SPT_OFS_PEND, 8'h00);
        chk(rd, 32'h26);
        apb(0, `SPT_OFS_DATA, 8'h00);
        chk(rd, 32'h5B);
        apb(1, `SPT_OFS_PEND, 8'h00);
        apb(1, `SPT_OFS_CTRL, 8'hB2);
        peer.send({2'b10, 8'h77, 1'b0}, 11);
        apb(0, `SPT_OFS_PEND, 8'h00);
        chk(rd, 32'h0);
        chk(rx_irq, 32'h0);
        peer.send({2'b11, 8'h21, 1'b0}, 11);
        apb(0, `SPT_OFS_PEND, 8'h00);
        chk(rd, 32'h2);
        chk(rx_irq, 32'h1);
        apb(0, `SPT_OFS_CTRL, 8'h00);
        chk(rd, 32'hB6);
        apb(0, `SPT_OFS_DATA, 8'h00);
        chk(rd, 32'h21);
        $display("test async9 done");
    endtask
    task automatic t_sync;
        apb(1, `SPT_OFS_CTRL, 8'h00);
        sync_mode <= 1'b1;
        apb(1, `SPT_OFS_PEND, 8'h00);
        apb(1, `SPT_OFS_DATA, 8'h96);
        repeat (160) @(posedge pclk);
        chk(peer.cap_reg, 32'h96);
        peer.drv_reg <= 8'hC3;
        apb(1, `SPT_OFS_PEND, 8'h00);
        apb(1, `SPT_OFS_CTRL, 8'h30);
        repeat (160) @(posedge pclk);
        apb(0, `SPT_OFS_DATA, 8'h00);
        chk(rd, 32'hC3);
        $display("test sync done");
    endtask
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        t_regs;
        t_async8;
        t_async9;
        t_sync;
        wrap_up;
    end
    initial begin
        repeat (30000) @(posedge pclk);
        failures++;
        $display("[FAIL] t=%0t timeout got=%h exp=%h", $time, 1'b1, 1'b0);
        wrap_up;
    end
endmodule
